// ===== rtl/pdw_power_ctrl.sv
// power-down control with wakeup timer and watchdog
//
// Notes on behaviour
// - power-down halts the processor clock; ram and registers keep their values.
// - the tick source and enabled timers keep running during power-down.
// - leave power-down on enabled pin a or b, timer expiry, or watchdog reset.
// - converter and radio power switches follow software, independent of power-down.
// - the slow tick source has no disable and runs while powered.
// - wakeup timer and watchdog are 16-bit counters on the slow tick.
// - shared tick period programmable, 300us to 80ms, 10ms after reset.
// - software starts and stops the wakeup timer at any time.
// - watchdog off after reset; once on, only reset turns it off.
// - software starts and stops the crystal oscillator.
// - wakeup timer expiry raises its own interrupt request.
`timescale 1ns/100ps
`default_nettype none
module pdw_power_ctrl #(
  parameter logic [23:0] TICK_RESET = pdw_pkg::TICK_RESET
) (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        ext_wake_pin_a,
  input  wire logic        ext_wake_pin_b,
  input  wire logic        pin_a_wake_en,
  input  wire logic        pin_b_wake_en,
  input  wire logic        power_down_req,
  input  wire logic        adc_on,
  input  wire logic        radio_on,
  input  wire logic        xtal_on,
  input  wire logic        tick_wr,
  input  wire logic [23:0] tick_period,
  input  wire logic        wut_start,
  input  wire logic        wut_stop,
  input  wire logic        wut_reload_mode,
  input  wire logic [15:0] wut_count,
  input  wire logic        wut_flag_clr,
  input  wire logic        wdog_enable,
  input  wire logic        wdog_kick,
  input  wire logic [15:0] wdog_timeout,
  output logic             cpu_halt,
  output logic             adc_power,
  output logic             radio_power,
  output logic             xtal_run,
  output logic             wut_irq,
  output logic             wut_running,
  output logic             wdog_active,
  output logic             wdog_reset_out,
  output logic [15:0]      wut_value
);
  typedef struct packed {
    pdw_pkg::pdw_mode_e mode;
    logic [1:0]  sync_a;
    logic [1:0]  sync_b;
    logic [23:0] period;
    logic        wut_run;
    logic [15:0] wut_cnt;
    logic        wut_flag;
    logic        wd_on;
    logic [15:0] wd_cnt;
    logic [4:0]  rst_cnt;
    logic        adc;
    logic        radio;
    logic        xtal;
  } pdw_st_s;

  pdw_st_s st_reg;
  pdw_st_s st_next;
  pdw_tick_if tk ();

  pdw_tick_gen u_tick (
    .clock (clock),
    .rst_b (rst_b),
    .tk    (tk.src)
  );

  assign tk.period = st_reg.period;

  logic pin_wake;
  logic wut_hit;
  logic wd_hit;
  // pins are active low
  assign pin_wake = (pin_a_wake_en && !st_reg.sync_a[1])
                 || (pin_b_wake_en && !st_reg.sync_b[1]);
  assign wut_hit  = st_reg.wut_run && tk.tick
                 && (st_reg.wut_cnt + pdw_pkg::TIMER_ONE >= wut_count);
  assign wd_hit   = st_reg.wd_on && tk.tick && !wdog_kick
                 && (st_reg.wd_cnt + pdw_pkg::TIMER_ONE >= wdog_timeout);

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_next        = st_reg;
    st_next.sync_a = {st_reg.sync_a[0], ext_wake_pin_a};
    st_next.sync_b = {st_reg.sync_b[0], ext_wake_pin_b};
    st_next.adc    = adc_on;
    st_next.radio  = radio_on;
    st_next.xtal   = xtal_on;
    if (tick_wr) begin
      st_next.period = tick_period;
    end
    // wakeup timer
    if (wut_start) begin
      st_next.wut_run = 1'b1;
      st_next.wut_cnt = pdw_pkg::TIMER_ZERO;
    end else if (wut_stop) begin
      st_next.wut_run = 1'b0;
    end else if (wut_hit) begin
      st_next.wut_cnt = pdw_pkg::TIMER_ZERO;
      st_next.wut_run = wut_reload_mode;
    end else if (st_reg.wut_run && tk.tick) begin
      st_next.wut_cnt = st_reg.wut_cnt + pdw_pkg::TIMER_ONE;
    end
    if (wut_hit) begin
      st_next.wut_flag = 1'b1;
    end else if (wut_flag_clr) begin
      st_next.wut_flag = 1'b0;
    end
    // watchdog
    if (wdog_enable) begin
      st_next.wd_on = 1'b1;
    end
    if (wdog_kick || !st_reg.wd_on) begin
      st_next.wd_cnt = pdw_pkg::TIMER_ZERO;
    end else if (tk.tick) begin
      st_next.wd_cnt = st_reg.wd_cnt + pdw_pkg::TIMER_ONE;
    end
    // mode machine
    case (st_reg.mode)
      pdw_pkg::PDW_RUN: begin
        if (wd_hit) begin
          st_next.mode    = pdw_pkg::PDW_WRST;
          st_next.rst_cnt = pdw_pkg::CNT5_ZERO;
        end else if (power_down_req) begin
          st_next.mode = pdw_pkg::PDW_DOWN;
        end
      end
      pdw_pkg::PDW_DOWN: begin
        if (wd_hit) begin
          st_next.mode    = pdw_pkg::PDW_WRST;
          st_next.rst_cnt = pdw_pkg::CNT5_ZERO;
        end else if (pin_wake || wut_hit) begin
          st_next.mode = pdw_pkg::PDW_RUN;
        end
      end
      pdw_pkg::PDW_WRST: begin
        st_next.rst_cnt = st_reg.rst_cnt + pdw_pkg::CNT5_ONE;
        if (st_reg.rst_cnt == pdw_pkg::WDOG_RST_LEN) begin
          // full internal reset of this block too
          st_next          = '0;
          st_next.sync_a   = 2'h3;
          st_next.sync_b   = 2'h3;
          st_next.period   = TICK_RESET;
          st_next.mode     = pdw_pkg::PDW_RUN;
          // switches keep following software through the reset
          st_next.adc      = adc_on;
          st_next.radio    = radio_on;
          st_next.xtal     = xtal_on;
        end
      end
      default: st_next.mode = pdw_pkg::PDW_RUN;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_reg        <= '0;
      st_reg.sync_a <= 2'h3;
      st_reg.sync_b <= 2'h3;
      st_reg.period <= TICK_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cpu_halt       <= 1'b0;
      adc_power      <= 1'b0;
      radio_power    <= 1'b0;
      xtal_run       <= 1'b0;
      wut_irq        <= 1'b0;
      wut_running    <= 1'b0;
      wdog_active    <= 1'b0;
      wdog_reset_out <= 1'b0;
      wut_value      <= pdw_pkg::TIMER_ZERO;
    end else begin
      cpu_halt       <= st_next.mode == pdw_pkg::PDW_DOWN;
      adc_power      <= st_next.adc;
      radio_power    <= st_next.radio;
      xtal_run       <= st_next.xtal;
      wut_irq        <= st_next.wut_flag;
      wut_running    <= st_next.wut_run;
      wdog_active    <= st_next.wd_on;
      wdog_reset_out <= st_next.mode == pdw_pkg::PDW_WRST;
      wut_value      <= st_next.wut_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  wdog_sticky_a: assert property (@(posedge clock) disable iff (!rst_b)
    st_reg.wd_on && st_reg.mode != pdw_pkg::PDW_WRST |=> st_reg.wd_on)
    else $error("watchdog turned off without reset");
  wdog_fires_a: assert property (@(posedge clock) disable iff (!rst_b)
    wd_hit && st_reg.mode != pdw_pkg::PDW_WRST |=> wdog_reset_out)
    else $error("watchdog timeout gave no reset");
  wake_pin_a: assert property (@(posedge clock) disable iff (!rst_b)
    st_reg.mode == pdw_pkg::PDW_DOWN && pin_wake && !wd_hit
      |=> !cpu_halt)
    else $error("enabled pin did not wake");
  halt_entry_a: assert property (@(posedge clock) disable iff (!rst_b)
    st_reg.mode == pdw_pkg::PDW_RUN && power_down_req && !wd_hit
      |=> cpu_halt)
    else $error("power-down not entered");
  timer_flag_a: assert property (@(posedge clock) disable iff (!rst_b)
    wut_hit && st_reg.mode != pdw_pkg::PDW_WRST |=> wut_irq)
    else $error("timer expiry set no flag");
  timer_stop_a: assert property (@(posedge clock) disable iff (!rst_b)
    wut_stop && !wut_start |=> !wut_running)
    else $error("timer did not stop");
  down_counts_a: assert property (@(posedge clock) disable iff (!rst_b)
    st_reg.mode == pdw_pkg::PDW_DOWN && st_reg.wut_run && tk.tick
      && !wut_hit && !wut_start && !wut_stop
      |=> st_reg.wut_cnt == $past(st_reg.wut_cnt) + pdw_pkg::TIMER_ONE)
    else $error("timer froze in power-down");
  power_follow_a: assert property (@(posedge clock) disable iff (!rst_b)
    ##1 adc_power == $past(adc_on) && radio_power == $past(radio_on))
    else $error("power switch not followed");
  xtal_follow_a: assert property (@(posedge clock) disable iff (!rst_b)
    ##1 xtal_run == $past(xtal_on))
    else $error("oscillator switch not followed");
endmodule
`default_nettype wire

// ===== shared/pdw_pkg.sv
// constants and types for the power-down, wakeup timer and watchdog block
package pdw_pkg;
  localparam int unsigned CLK_MHZ        = 100;
  // tick period of the slow rc clock domain, microseconds
  localparam int unsigned TICK_MIN_US    = 300;
  localparam int unsigned TICK_MAX_US    = 80000;
  localparam int unsigned TICK_RESET_US  = 10000;
  localparam int unsigned TICK_RESET_CYC = TICK_RESET_US * CLK_MHZ;
  localparam int unsigned TIMER_W        = 16;
  localparam int unsigned PRESC_W        = 24;
  localparam logic [15:0] TIMER_ZERO     = 16'h0000;
  localparam logic [15:0] TIMER_ONE      = 16'h0001;
  localparam logic [23:0] PRESC_ZERO     = 24'h000000;
  localparam logic [23:0] PRESC_ONE      = 24'h000001;
  localparam logic [23:0] TICK_RESET     = 24'(TICK_RESET_CYC);
  localparam int unsigned WDOG_RST_CYC   = 16;
  localparam logic [4:0]  WDOG_RST_LEN   = 5'(WDOG_RST_CYC);
  localparam logic [4:0]  CNT5_ZERO      = 5'h00;
  localparam logic [4:0]  CNT5_ONE       = 5'h01;

  typedef enum logic [1:0] {
    PDW_RUN,
    PDW_DOWN,
    PDW_WRST
  } pdw_mode_e;
endpackage

// ===== shared/pdw_tick_if.sv
// tick carrier between the prescaler and the timers
`timescale 1ns/100ps
`default_nettype none
interface pdw_tick_if;
  logic        tick;
  logic [23:0] period;
  modport src (output tick, input period);
  modport dst (input tick, output period);
endinterface
`default_nettype wire

// ===== rtl/pdw_tick_gen.sv
// shared tick prescaler standing in for the slow rc clock
`timescale 1ns/100ps
`default_nettype none
module pdw_tick_gen (
  input  wire logic clock,
  input  wire logic rst_b,
  pdw_tick_if.src   tk
);
  typedef struct packed {
    logic [23:0] cnt;
    logic        tick;
  } pdw_tg_s;

  pdw_tg_s st_reg;
  pdw_tg_s st_next;

  // free running, no disable input exists
  always_comb begin
    st_next      = st_reg;
    st_next.tick = 1'b0;
    if (st_reg.cnt >= tk.period - pdw_pkg::PRESC_ONE) begin
      st_next.cnt  = pdw_pkg::PRESC_ZERO;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + pdw_pkg::PRESC_ONE;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tk.tick = st_reg.tick;

  tick_runs_a: assert property (@(posedge clock) disable iff (!rst_b)
    (st_reg.cnt == pdw_pkg::PRESC_ZERO && !st_reg.tick)
      |-> ##1 st_reg.cnt == pdw_pkg::PRESC_ONE || st_reg.tick)
    else $error("prescaler stalled");
endmodule
`default_nettype wire

// ===== sim/tb.sv
// self-checking bench for the power-down, wakeup timer and watchdog block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  mismatches++; $display("unexpected %s exp %0h got %0h", nm, e, g); end end
`define WAIT(s, lv, lim) begin n = 0; @(negedge clock); \
  while ((s) !== (lv) && n < (lim)) begin @(negedge clock); n++; end end
module tb;
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic        pa = 1'b1, pb = 1'b1, ea = 1'b0, eb = 1'b0, pd = 1'b0;
  logic        adc = 1'b0, rad = 1'b0, xt = 1'b0, twr = 1'b0, ws = 1'b0;
  logic        wp = 1'b0, rm = 1'b0, fc = 1'b0, we = 1'b0, wk = 1'b0;
  logic [15:0] wc = 16'h0002;
  logic [15:0] wt = 16'h0003;
  logic        halt, adcp, radp, xtr, irq, run, wact, wrst;
  logic [15:0] val;
  logic [15:0] v;
  int          mismatches = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          n = 0;

  pdw_power_ctrl #(.TICK_RESET(24'h000014)) u_dut (
    .clock(clock), .rst_b(rst_b), .ext_wake_pin_a(pa), .ext_wake_pin_b(pb),
    .pin_a_wake_en(ea), .pin_b_wake_en(eb), .power_down_req(pd),
    .adc_on(adc), .radio_on(rad), .xtal_on(xt), .tick_wr(twr),
    .tick_period(24'h00000a), .wut_start(ws), .wut_stop(wp),
    .wut_reload_mode(rm), .wut_count(wc), .wut_flag_clr(fc),
    .wdog_enable(we), .wdog_kick(wk), .wdog_timeout(wt), .cpu_halt(halt),
    .adc_power(adcp), .radio_power(radp), .xtal_run(xtr), .wut_irq(irq),
    .wut_running(run), .wdog_active(wact), .wdog_reset_out(wrst),
    .wut_value(val)
  );

  always #5 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////////
  task end_of_test();
    if (mismatches == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task cyc(input int k);
    repeat (k) @(posedge clock);
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(3);
    rst_b <= 1'b1;
    @(negedge clock);
    `CHK("halt", 1'b0, halt)
    `CHK("wdog on", 1'b0, wact)
    `CHK("wdog rst", 1'b0, wrst)
    `CHK("irq", 1'b0, irq)
    // one-shot run on the reset tick period
    cyc(1);
    ws <= 1'b1;
    cyc(1);
    ws <= 1'b0;
    `WAIT(irq, 1'b1, 100)
    `CHK("reset tick", 1'b1, n >= 15 && n <= 45)
    cyc(2);
    @(negedge clock);
    `CHK("one-shot", 1'b0, run)
    cyc(1);
    fc <= 1'b1;
    twr <= 1'b1;
    cyc(1);
    fc <= 1'b0;
    twr <= 1'b0;
    cyc(3);
    @(negedge clock);
    `CHK("flag clr", 1'b0, irq)
    // reload mode on a short tick
    cyc(1);
    rm <= 1'b1;
    wc <= 16'h0003;
    ws <= 1'b1;
    cyc(1);
    ws <= 1'b0;
    `WAIT(irq, 1'b1, 60)
    `CHK("expiry", 1'b1, n >= 20 && n <= 40)
    cyc(1);
    fc <= 1'b1;
    cyc(1);
    fc <= 1'b0;
    `WAIT(irq, 1'b1, 60)
    `CHK("rerun", 1'b1, n >= 20 && n <= 40)
    `CHK("running", 1'b1, run)
    cyc(1);
    wp <= 1'b1;
    fc <= 1'b1;
    rm <= 1'b0;
    cyc(1);
    wp <= 1'b0;
    fc <= 1'b0;
    cyc(3);
    @(negedge clock);
    `CHK("stopped", 1'b0, run)
    v = val;
    cyc(40);
    @(negedge clock);
    `CHK("frozen", v, val)
    // power-down, switches and pin wake
    cyc(1);
    adc <= 1'b1;
    xt <= 1'b1;
    pd <= 1'b1;
    cyc(1);
    pd <= 1'b0;
    cyc(3);
    @(negedge clock);
    `CHK("halted", 1'b1, halt)
    `CHK("adc pwr", 1'b1, adcp)
    `CHK("xtal", 1'b1, xtr)
    cyc(1);
    rad <= 1'b1;
    pb <= 1'b0;
    cyc(8);
    @(negedge clock);
    `CHK("radio pwr", 1'b1, radp)
    `CHK("pin b off", 1'b1, halt)
    cyc(1);
    ea <= 1'b1;
    pa <= 1'b0;
    `WAIT(halt, 1'b0, 8)
    `CHK("pin a wake", 1'b1, n < 8)
    cyc(1);
    pa <= 1'b1;
    pb <= 1'b1;
    ea <= 1'b0;
    cyc(3);
    eb <= 1'b1;
    pd <= 1'b1;
    cyc(1);
    pd <= 1'b0;
    cyc(4);
    @(negedge clock);
    `CHK("pin b idle", 1'b1, halt)
    cyc(1);
    pb <= 1'b0;
    `WAIT(halt, 1'b0, 8)
    `CHK("pin b wake", 1'b1, n < 8)
    cyc(1);
    pb <= 1'b1;
    eb <= 1'b0;
    adc <= 1'b0;
    rad <= 1'b0;
    xt <= 1'b0;
    wc <= 16'h0002;
    ws <= 1'b1;
    pd <= 1'b1;
    cyc(1);
    ws <= 1'b0;
    pd <= 1'b0;
    cyc(2);
    @(negedge clock);
    `CHK("adc off", 1'b0, adcp)
    `CHK("radio off", 1'b0, radp)
    `CHK("xtal off", 1'b0, xtr)
    `CHK("down again", 1'b1, halt)
    `WAIT(halt, 1'b0, 40)
    `CHK("timer wake", 1'b1, n < 40)
    // watchdog: sticky enable, kicks, timeout
    cyc(1);
    fc <= 1'b1;
    we <= 1'b1;
    cyc(1);
    fc <= 1'b0;
    we <= 1'b0;
    repeat (8) begin
      cyc(15);
      wk <= 1'b1;
      cyc(1);
      wk <= 1'b0;
    end
    @(negedge clock);
    `CHK("kicked", 1'b0, wrst)
    `CHK("sticky", 1'b1, wact)
    cyc(1);
    pd <= 1'b1;
    cyc(1);
    pd <= 1'b0;
    `WAIT(wrst, 1'b1, 50)
    `CHK("timeout", 1'b1, n < 50)
    `WAIT(wrst, 1'b0, 30)
    `CHK("rst len", pdw_pkg::WDOG_RST_CYC, n)
    cyc(2);
    @(negedge clock);
    `CHK("wdog clr", 1'b0, wact)
    `CHK("wdog wake", 1'b0, halt)
    end_of_test();
  end
endmodule
`default_nettype wire
